/* src/cptd_detector.sv */
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "cptd_defs.svh"
module cptd_detector #(
   parameter int DCD_TIMEOUT = `CPTD_DCD_TIMEOUT,
   parameter int DWELL       = `CPTD_DWELL
) (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   // Avalon-MM slave
   input  wire logic [5:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic      [31:0]          avs_readdata,
   output logic                      avs_waitrequest,
   // Pins and analog front end
   input  wire logic                 vbus_present,
   input  wire logic                 host_mode,
   input  wire logic                 battery_good,
   input  wire logic                 limit_select_pin_a,
   input  wire logic                 limit_select_pin_b,
   input  wire cptd_pkg::cptd_sense_t sense,
   output cptd_pkg::cptd_drive_t     drive,
   // Results
   output cptd_pkg::cptd_cfg_t       cfg,
   output cptd_pkg::cptd_port_t      port_type,
   output logic                      detect_done,
   output logic                      power_good_output_o,
   output logic                      power_good_output_oe_n
);
   // Seven states in three bits: the eighth code is illegal and recovers to idle
   typedef enum logic [2:0] {
      CPTD_IDLE,
      CPTD_DCD,
      CPTD_PRI,
      CPTD_SEC_CHG,
      CPTD_SEC_STD,
      CPTD_NSA,
      CPTD_CFG
   } cptd_state_t;

   // Synchronised pins
   logic       vbus_s, host_s, batt_s, pin_a_s, pin_b_s;
   logic [3:0] sense_s;
   cptd_sync #(.W(9)) u_sync (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .async_in ({vbus_present, host_mode, battery_good, limit_select_pin_a,
                  limit_select_pin_b, sense}),
      .sync_out ({vbus_s, host_s, batt_s, pin_a_s, pin_b_s, sense_s})
   );
   cptd_pkg::cptd_sense_t sn;
   assign sn = cptd_pkg::cptd_sense_t'(sense_s);

   cptd_state_t          state_ff, nxt_state;
   logic [31:0]          dwell_ff;
   logic [31:0]          dcd_ff;
   logic                 vbus_d_ff;
   logic                 force_ff;
   logic                 run_host_ff;
   logic                 done_ff;
   logic                 dsrc_ff;
   logic [1:0]           pins_ff;
   logic                 pins_armed_ff;
   cptd_pkg::cptd_port_t port_ff, nxt_port;
   cptd_pkg::cptd_cfg_t  cfg_ff;
   logic                 rd_ready_ff;

   // Host-mode runs can only start through the force bit
   wire vbus_rise   = vbus_s & ~vbus_d_ff;
   wire start       = (vbus_rise & ~host_s) | force_ff;
   wire dwell_done  = (dwell_ff >= DWELL - 1);
   wire dcd_expired = (dcd_ff >= DCD_TIMEOUT - 1);

   // Bus decode
   wire        wr     = avs_write & avs_byteenable[0];
   wire [3:0]  idx    = avs_address[5:2];
   wire        wr_ctl = wr & (idx == `CPTD_IDX_CTRL) & avs_writedata[`CPTD_BIT_FORCE];
   wire        wr_clr = wr & (idx == `CPTD_IDX_VDP) & avs_writedata[`CPTD_BIT_DPLUS_SOURCE_CLEAR_BIT];

   // One wait state on reads so that read data stand when waitrequest drops;
   // writes take effect with no wait
   always_ff @(posedge ref_clk) begin
      if (reset)
         rd_ready_ff <= 1'b0;
      else
         rd_ready_ff <= avs_read & ~rd_ready_ff;
   end

   assign avs_waitrequest = avs_read & ~rd_ready_ff;

   // Force bit: one-shot request, cleared once the sequencer starts
   always_ff @(posedge ref_clk) begin
      if (reset)
         force_ff <= 1'b0;
      else if (wr_ctl)
         force_ff <= 1'b1;
      else if (state_ff == CPTD_DCD)
         force_ff <= 1'b0;
   end

   // Edge detect on synced VBUS; idles low like the pin, so no false edge after reset
   always_ff @(posedge ref_clk) begin
      if (reset)
         vbus_d_ff <= 1'b0;
      else
         vbus_d_ff <= vbus_s;
   end

   // Sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_port  = port_ff;
      unique case (state_ff)
         CPTD_IDLE: begin
            if (start)
               nxt_state = CPTD_DCD;
         end
         CPTD_DCD: begin
            if (dcd_expired)
               nxt_state = CPTD_NSA;
            else if (sn.contact && dwell_done)
               nxt_state = CPTD_PRI;
         end
         CPTD_PRI: begin
            if (dwell_done)
               nxt_state = sn.primary_hi ? CPTD_SEC_CHG : CPTD_SEC_STD;
         end
         CPTD_SEC_CHG: if (dwell_done) begin
            nxt_port  = sn.secondary_hi ? cptd_pkg::CPTD_PORT_DCP
                                        : cptd_pkg::CPTD_PORT_CDP;
            nxt_state = CPTD_CFG;
         end
         CPTD_SEC_STD: if (dwell_done) begin
            nxt_port  = sn.nsa_pass ? cptd_pkg::CPTD_PORT_NSA
                                    : cptd_pkg::CPTD_PORT_SDP;
            nxt_state = CPTD_CFG;
         end
         CPTD_NSA: if (dwell_done) begin
            if (sn.nsa_pass) begin
               nxt_port  = cptd_pkg::CPTD_PORT_NSA;
               nxt_state = CPTD_CFG;
            end else
               nxt_state = CPTD_PRI;
         end
         CPTD_CFG: nxt_state = CPTD_IDLE;
         default: begin
            nxt_state = CPTD_IDLE;
            nxt_port  = cptd_pkg::CPTD_PORT_NONE;
         end
      endcase
      if (start && state_ff != CPTD_IDLE && state_ff != CPTD_DCD)
         nxt_state = CPTD_DCD;
   end

   always_ff @(posedge ref_clk) begin
      if (reset)
         state_ff <= CPTD_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Dwell restarts on every state change
   always_ff @(posedge ref_clk) begin
      if (reset || nxt_state != state_ff)
         dwell_ff <= '0;
      else if (!dwell_done)
         dwell_ff <= dwell_ff + 32'd1;
   end

   // Contact timer runs only inside contact detect
   always_ff @(posedge ref_clk) begin
      if (reset || state_ff != CPTD_DCD)
         dcd_ff <= '0;
      else if (!dcd_expired)
         dcd_ff <= dcd_ff + 32'd1;
   end

   // Result stays until the next start
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         port_ff     <= cptd_pkg::CPTD_PORT_NONE;
         done_ff     <= 1'b0;
         run_host_ff <= 1'b0;
      end else if (start && state_ff == CPTD_IDLE) begin
         port_ff     <= cptd_pkg::CPTD_PORT_NONE;
         done_ff     <= 1'b0;
         run_host_ff <= host_s;
      end else begin
         port_ff <= nxt_port;
         if (state_ff == CPTD_CFG)
            done_ff <= 1'b1;
      end
   end

   // Configuration table; ACA behind OTG reads as non-standard, giving 500 mA
   function automatic cptd_pkg::cptd_cfg_t cfg_of(input cptd_pkg::cptd_port_t p,
                                                  input logic good);
      cfg_of.valid = 1'b1;
      unique case (p)
         cptd_pkg::CPTD_PORT_DCP: begin
            cfg_of.input_limit_resistor_pin = `CPTD_LIM_EXT;
            cfg_of.tmr  = `CPTD_TMR_6HR;
         end
         cptd_pkg::CPTD_PORT_NSA: begin
            cfg_of.input_limit_resistor_pin = `CPTD_LIM_500;
            cfg_of.tmr  = `CPTD_TMR_6HR;
         end
         cptd_pkg::CPTD_PORT_CDP: begin
            cfg_of.input_limit_resistor_pin = good ? `CPTD_LIM_1500 : `CPTD_LIM_100;
            cfg_of.tmr  = good ? `CPTD_TMR_6HR  : `CPTD_TMR_45MIN;
         end
         cptd_pkg::CPTD_PORT_SDP: begin
            cfg_of.input_limit_resistor_pin = good ? `CPTD_LIM_HIZ  : `CPTD_LIM_100;
            cfg_of.tmr  = good ? `CPTD_TMR_NONE : `CPTD_TMR_45MIN;
         end
         default: begin
            cfg_of.valid = 1'b0;
            cfg_of.input_limit_resistor_pin  = `CPTD_LIM_100;
            cfg_of.tmr   = `CPTD_TMR_NONE;
         end
      endcase
   endfunction

   // Limit pins: truth table by pin pair {b,a}
   function automatic logic [2:0] pin_lim(input logic [1:0] ba);
      unique case (ba)
         2'h0:    pin_lim = `CPTD_LIM_500;
         2'h1:    pin_lim = `CPTD_LIM_EXT;
         2'h2:    pin_lim = `CPTD_LIM_100;
         default: pin_lim = `CPTD_LIM_HIZ;
      endcase
   endfunction

   // Probes follow the next state so the front end settles during the dwell;
   // the standard branch arms the non-standard comparator to tell SDP from NSA
   function automatic cptd_pkg::cptd_drive_t probe_of(input cptd_state_t s,
                                                     input logic        src);
      probe_of.dcd_en    = (s == CPTD_DCD);
      probe_of.pri_en    = (s == CPTD_PRI);
      probe_of.sec_en    = (s == CPTD_SEC_CHG) || (s == CPTD_SEC_STD);
      probe_of.nsa_en    = (s == CPTD_NSA) || (s == CPTD_SEC_STD);
      probe_of.dplus_src = src;
   endfunction

   // Dead-battery provision only concerns the two downstream port kinds
   function automatic logic is_downstream(input cptd_pkg::cptd_port_t p);
      is_downstream = (p == cptd_pkg::CPTD_PORT_CDP) || (p == cptd_pkg::CPTD_PORT_SDP);
   endfunction

   // Pins are sampled every cycle; only a change after completion applies them
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pins_ff       <= 2'h0;
         pins_armed_ff <= 1'b0;
      end else begin
         pins_ff <= {pin_b_s, pin_a_s};
         if (!done_ff)
            pins_armed_ff <= 1'b0;
         else if (pins_ff != {pin_b_s, pin_a_s})
            pins_armed_ff <= 1'b1;
      end
   end

   // Applied configuration; host-mode runs leave it untouched
   always_ff @(posedge ref_clk) begin
      if (reset)
         cfg_ff <= '0;
      else if (state_ff == CPTD_CFG && !run_host_ff)
         cfg_ff <= cfg_of(nxt_port, batt_s);
      else if (done_ff && pins_armed_ff && !run_host_ff)
         cfg_ff <= '{valid: 1'b1, input_limit_resistor_pin: pin_lim(pins_ff), tmr: cfg_ff.tmr};
   end

   // D+ source during dead-battery wakeup, cleared by software
   always_ff @(posedge ref_clk) begin
      if (reset)
         dsrc_ff <= 1'b0;
      else if (wr_clr)
         dsrc_ff <= 1'b0;
      else if (state_ff == CPTD_CFG && !batt_s && is_downstream(nxt_port))
         dsrc_ff <= 1'b1;
      else if (start)
         dsrc_ff <= 1'b0;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         drive <= '0;
      end else begin
         drive <= probe_of(nxt_state, dsrc_ff);
      end
   end

   // Read path: loaded in the wait cycle, held through the accepting edge
   always_ff @(posedge ref_clk) begin
      if (reset)
         avs_readdata <= '0;
      else if (avs_read && !rd_ready_ff) begin
         unique case (idx)
            `CPTD_IDX_STATUS: avs_readdata <= {26'h0, dsrc_ff, done_ff, state_ff,
                                               host_s};
            `CPTD_IDX_RESULT: avs_readdata <= {24'h0, cfg_ff.valid, cfg_ff.tmr,
                                               cfg_ff.input_limit_resistor_pin, 2'h0} | {29'h0, port_ff};
            `CPTD_IDX_CTRL:   avs_readdata <= {27'h0, force_ff, 4'h0};
            default:          avs_readdata <= 32'h0;
         endcase
      end
   end

   assign cfg                    = cfg_ff;
   assign port_type              = port_ff;
   assign detect_done            = done_ff;
   // Open drain, active low power good; released (Hi-Z) until done
   assign power_good_output_o    = 1'b0;
   assign power_good_output_oe_n = ~(done_ff & vbus_s);
endmodule

/* src/cptd_defs.svh */
`ifndef CPTD_DEFS_SVH
`define CPTD_DEFS_SVH
// Register word indices; the byte address is the index times four
`define CPTD_IDX_CTRL       4'h4
`define CPTD_IDX_VDP        4'h7
`define CPTD_IDX_STATUS     4'h8
`define CPTD_IDX_RESULT     4'h9
`define CPTD_ADDR_W         6
// Field positions
`define CPTD_BIT_FORCE      4
`define CPTD_BIT_DPLUS_SOURCE_CLEAR_BIT    4
`define CPTD_BIT_HOST_MODE  0
// Input current limit codes
`define CPTD_LIM_100        3'h0
`define CPTD_LIM_500        3'h1
`define CPTD_LIM_1500       3'h2
`define CPTD_LIM_EXT        3'h3
`define CPTD_LIM_HIZ        3'h4
// Safety timer codes
`define CPTD_TMR_NONE       2'h0
`define CPTD_TMR_45MIN      2'h1
`define CPTD_TMR_6HR        2'h2
// Timing counts in cycles
`define CPTD_DCD_TIMEOUT    32'd50000
`define CPTD_DWELL          32'd1000
`endif

/* src/cptd_pkg.sv */
package cptd_pkg;
   typedef enum logic [2:0] {
      CPTD_PORT_NONE,
      CPTD_PORT_DCP,
      CPTD_PORT_CDP,
      CPTD_PORT_SDP,
      CPTD_PORT_NSA
   } cptd_port_t;

   // Analog comparator results from the D+/D- front end
   typedef struct packed {
      logic contact;
      logic primary_hi;
      logic secondary_hi;
      logic nsa_pass;
   } cptd_sense_t;

   // Line drive requests to the D+/D- front end
   typedef struct packed {
      logic dcd_en;
      logic pri_en;
      logic sec_en;
      logic nsa_en;
      logic dplus_src;
   } cptd_drive_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] input_limit_resistor_pin;
      logic [1:0] tmr;
   } cptd_cfg_t;
endpackage

/* src/cptd_sync.sv */
`timescale 1ns/1ps
module cptd_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         reset,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] stage1_ff;
   logic [W-1:0] stage2_ff;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
      end else begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign sync_out = stage2_ff;
endmodule

/* test/cptd_detector_props.sv */
`timescale 1ns/1ps
`include "cptd_defs.svh"
module cptd_detector_props (
   // Clock and reset
   input wire logic                  ref_clk,
   input wire logic                  reset,
   // Bus side
   input wire logic [5:0]            avs_address,
   input wire logic                  avs_write,
   input wire logic [31:0]           avs_writedata,
   input wire logic [3:0]            avs_byteenable,
   // Results
   input wire cptd_pkg::cptd_drive_t drive,
   input wire cptd_pkg::cptd_cfg_t   cfg,
   input wire cptd_pkg::cptd_port_t  port_type,
   input wire logic                  detect_done,
   input wire logic                  power_good_output_oe_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic ever_done_ff;
   always_ff @(posedge ref_clk) begin
      if (reset)
         ever_done_ff <= 1'b0;
      else if (detect_done)
         ever_done_ff <= 1'b1;
   end
   // Bounds are generous so that slow dwell settings still fit
   sequence s_primary_or_nsa;
      ##[0:40] (drive.pri_en || drive.nsa_en);
   endsequence
   sequence s_secondary;
      ##[0:40] drive.sec_en;
   endsequence
   sequence s_finished;
      ##[0:40] detect_done;
   endsequence
   chk_pg_released: assert property (!ever_done_ff && !detect_done |-> power_good_output_oe_n)
      else $error("power good driven before detection finished");
   chk_type_held: assert property (detect_done && $past(detect_done) |-> $stable(port_type))
      else $error("port type moved while done");
   chk_one_probe: assert property ($onehot0({drive.dcd_en, drive.pri_en, drive.sec_en,
      drive.nsa_en && !drive.sec_en}))
      else $error("more than one probe state active");
   chk_dcp_config: assert property ($rose(cfg.valid) && port_type == cptd_pkg::CPTD_PORT_DCP
      |-> cfg.input_limit_resistor_pin == `CPTD_LIM_EXT && cfg.tmr == `CPTD_TMR_6HR)
      else $error("dedicated port configured wrongly");
   chk_dcd_exit: assert property ($fell(drive.dcd_en) |-> s_primary_or_nsa)
      else $error("contact detect left to nowhere");
   chk_primary_exit: assert property ($fell(drive.pri_en) |-> s_secondary)
      else $error("primary detection not followed by secondary");
   chk_secondary_exit: assert property ($fell(drive.sec_en) |-> s_finished)
      else $error("secondary detection did not finish");
   chk_nsa_exit: assert property ($fell(drive.nsa_en) |-> ##[0:40] (detect_done || drive.pri_en))
      else $error("non-standard detection exit wrong");
   chk_dplus_clear: assert property (avs_write && avs_byteenable[0] && avs_address == 6'h1C
      && avs_writedata[4] |-> ##[1:6] !drive.dplus_src)
      else $error("D+ source not removed");
endmodule
bind cptd_detector cptd_detector_props i_props (.ref_clk, .reset, .avs_address, .avs_write,
   .avs_writedata, .avs_byteenable, .drive, .cfg, .port_type, .detect_done,
   .power_good_output_oe_n);

/* test/cptd_port_model.sv */
`timescale 1ns/1ps
module cptd_port_model (
   // Attached port
   input wire cptd_pkg::cptd_port_t  kind,
   input wire logic                  contact_ok,
   // Front end
   input wire cptd_pkg::cptd_drive_t drive,
   output cptd_pkg::cptd_sense_t     sense
);
   // Comparators read low whenever their probe is off; nsa_pass reads with either the secondary or the non-standard probe on
   always_comb begin
      sense.contact      = drive.dcd_en && contact_ok;
      sense.primary_hi   = drive.pri_en && (kind == cptd_pkg::CPTD_PORT_DCP
                           || kind == cptd_pkg::CPTD_PORT_CDP);
      sense.secondary_hi = drive.sec_en && kind == cptd_pkg::CPTD_PORT_DCP;
      sense.nsa_pass     = (drive.sec_en || drive.nsa_en) && kind == cptd_pkg::CPTD_PORT_NSA;
   end
endmodule

/* test/charger_port_type_detector_bench.sv */
`timescale 1ns/1ps
`include "cptd_defs.svh"
module charger_port_type_detector_bench;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic vbus_present = 1'b0;
   logic host_mode = 1'b0;
   logic battery_good = 1'b1;
   logic pin_a = 1'b0;
   logic pin_b = 1'b0;
   logic contact_ok = 1'b1;
   logic pg_o;
   logic pg_oe_n;
   logic detect_done;
   logic [31:0] rd;
   cptd_pkg::cptd_port_t kind = cptd_pkg::CPTD_PORT_NONE;
   cptd_pkg::cptd_port_t port_type;
   cptd_pkg::cptd_sense_t sense;
   cptd_pkg::cptd_drive_t drive;
   cptd_pkg::cptd_cfg_t cfg;
   int mismatches = 0;
   int n_compared = 0;
   logic [2:0] k_tab [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h2, 3'h3};
   logic [2:0] l_tab [7] = '{3'h3, 3'h2, 3'h4, 3'h1, 3'h1, 3'h0, 3'h0};
   logic [1:0] m_tab [7] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1};
   logic [6:0] c_mask = 7'h6F;
   logic [6:0] g_mask = 7'h1F;
   always #5 ref_clk = ~ref_clk;
   cptd_detector #(.DCD_TIMEOUT(20), .DWELL(4)) i_dut (.ref_clk, .reset, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
      .avs_waitrequest, .vbus_present, .host_mode, .battery_good,
      .limit_select_pin_a(pin_a), .limit_select_pin_b(pin_b), .sense, .drive, .cfg,
      .port_type, .detect_done, .power_good_output_o(pg_o), .power_good_output_oe_n(pg_oe_n));
   cptd_port_model i_port (.kind, .contact_ok, .drive, .sense);
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Each request is held until waitrequest is sampled low at a rising edge
   task automatic bus_wait();
      do
         @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0);
   endtask
   task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      bus_wait();
      avs_write <= 1'b0;
   endtask
   // Read data are taken at the edge where waitrequest is sampled low
   task automatic bus_read(input logic [5:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      bus_wait();
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
   task automatic wait_done(input logic lvl);
      int n;
      n = 0;
      while (detect_done !== lvl && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      chk("detect_done", {31'h0, detect_done}, {31'h0, lvl});
   endtask
   task automatic replug(input logic [2:0] k, input logic c, input logic g);
      @(posedge ref_clk);
      kind <= cptd_pkg::cptd_port_t'(k);
      contact_ok <= c;
      battery_good <= g;
      vbus_present <= 1'b0;
      repeat (10) @(posedge ref_clk);
      vbus_present <= 1'b1;
   endtask
   initial begin
      repeat (30000) @(posedge ref_clk);
      mismatches++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      chk("pg_oe_n", {31'h0, pg_oe_n}, 32'h1);
      chk("pg_o", {31'h0, pg_o}, 32'h0);
      bus_read(6'h3C, rd);
      chk("unmapped read", rd, 32'h0);
      for (int i = 0; i < 7; i++) begin
         replug(k_tab[i], c_mask[i], g_mask[i]);
         wait_done(1'b0);
         wait_done(1'b1);
         repeat (3) @(posedge ref_clk);
         chk("port_type", {29'h0, port_type}, {29'h0, k_tab[i]});
         chk("input_limit_resistor_pin", {29'h0, cfg.input_limit_resistor_pin}, {29'h0, l_tab[i]});
         chk("tmr", {30'h0, cfg.tmr}, {30'h0, m_tab[i]});
         chk("cfg valid", {31'h0, cfg.valid}, 32'h1);
         chk("pg_oe_n done", {31'h0, pg_oe_n}, 32'h0);
      end
      chk("dplus_src", {31'h0, drive.dplus_src}, 32'h1);
      bus_write(6'h1C, 32'h10);
      repeat (6) @(posedge ref_clk);
      chk("dplus_src", {31'h0, drive.dplus_src}, 32'h0);
      bus_read(6'h20, rd);
      chk("status", rd, 32'h10);
      pin_a <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk("input_limit_resistor_pin pins", {29'h0, cfg.input_limit_resistor_pin}, {29'h0, `CPTD_LIM_EXT});
      host_mode <= 1'b1;
      repeat (5) @(posedge ref_clk);
      replug(3'h2, 1'b1, 1'b1);
      repeat (200) @(posedge ref_clk);
      chk("port_type host", {29'h0, port_type}, 32'h3);
      bus_write(6'h10, 32'h10);
      wait_done(1'b0);
      wait_done(1'b1);
      repeat (3) @(posedge ref_clk);
      chk("port_type forced", {29'h0, port_type}, 32'h2);
      chk("tmr kept", {30'h0, cfg.tmr}, {30'h0, `CPTD_TMR_45MIN});
      chk("input_limit_resistor_pin kept", {29'h0, cfg.input_limit_resistor_pin}, {29'h0, `CPTD_LIM_EXT});
      conclude();
   end
endmodule
